// ==== adcm_pkg.sv ====
// Shared constants, types and helpers of the converter mode-configuration port.
package adcm_pkg;

  // ==========================================================================
  // Serial word layout
  localparam int SERIAL_WORD_BITS = 16;
  localparam int HEADER_BITS = 8;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 8;
  localparam int CNT_BITS = 5;
  localparam int RW_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int HDR_RW_POS = 7;

  // ==========================================================================
  // Register offsets
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
  localparam logic [6:0] ADDR_OUTCLK_TIMING = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT_MODE = 7'h03;

  // ==========================================================================
  // Field positions and reset values
  localparam int SRST_BIT = 7;
  localparam int PWR_MSB = 1;
  localparam int TIM_MSB = 3;
  localparam int TIM_INV_BIT = 3;
  localparam int TIM_PHASE_MSB = 2;
  localparam int TIM_PHASE_LSB = 1;
  localparam int TIM_DCS_BIT = 0;
  localparam int OM_CURRENT_MSB = 6;
  localparam int OM_CURRENT_LSB = 4;
  localparam int OM_TERM_BIT = 3;
  localparam int OM_HIZ_BIT = 2;
  localparam int OM_MODE_MSB = 1;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [2:0] LVDS_CURRENT_DEFAULT = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Timing
  localparam int MCLK_PERIOD_PS = 8000;
  localparam int SRST_SLEEP_NS = 200;
  localparam int SRST_SLEEP_CYCLES =
    (SRST_SLEEP_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int SLEEP_CNT_BITS = 8;
  localparam int OUTCLK_STEP_BITS = 3;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    ADCM_PWR_NORMAL = 2'b00,
    ADCM_PWR_CH2_NAP = 2'b01,
    ADCM_PWR_BOTH_NAP = 2'b10,
    ADCM_PWR_SLEEP = 2'b11
  } adcm_power_type;

  typedef enum logic [1:0] {
    ADCM_OUT_FULL_CMOS = 2'b00,
    ADCM_OUT_DDR_LVDS = 2'b01,
    ADCM_OUT_DDR_CMOS = 2'b10
  } adcm_outmode_type;

  typedef struct packed {
    logic [7:0] out_mode;
    logic [3:0] timing;
    logic [1:0] power;
  } adcm_cfg_type;

  typedef struct packed {
    logic ch1_nap;
    logic ch2_nap;
    logic sleep;
  } adcm_pwr_ctl_type;

  localparam adcm_cfg_type CFG_RESET = '{
    out_mode: REG_RESET_VALUE,
    timing: 4'h0,
    power: 2'h0
  };

  // Channel one only naps together with channel two.
  function automatic adcm_pwr_ctl_type decode_power(input logic [1:0] ps);
    adcm_pwr_ctl_type r;
    r.ch1_nap = (ps == ADCM_PWR_BOTH_NAP);
    r.ch2_nap = (ps == ADCM_PWR_CH2_NAP) || (ps == ADCM_PWR_BOTH_NAP);
    r.sleep = (ps == ADCM_PWR_SLEEP);
    return r;
  endfunction

  // The reset register is write-only; it reads back as zero here.
  function automatic logic [7:0] reg_read(input logic [6:0] addr,
                                          input adcm_cfg_type cfg);
    logic [7:0] r;
    r = UNMAPPED_READ;
    if (addr == ADDR_POWER_DOWN)
      r = {6'h00, cfg.power};
    else if (addr == ADDR_OUTCLK_TIMING)
      r = {4'h0, cfg.timing};
    else if (addr == ADDR_OUTPUT_MODE)
      r = cfg.out_mode;
    return r;
  endfunction

endpackage

// ==== adcm_sync.sv ====
// Two-flop synchroniser for levels and toggles entering the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module adcm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== adcm_mode_config_port.sv ====
// Mode-configuration port: parallel strap pins or a 16-bit serial port.
// Operation
// - Output disable tristates outputs, overflow, clock.
// - Channel one never naps alone.
// - Select pin high makes port pins straps.
// - Parallel chip select sets duty stabilizer.
// - Parallel clock pin selects output mode.
// - Parallel data pins select power state.
// - Frame on chip select, first 16 edges.
// - Word is flag, address, then data.
// - Flag low writes, high reads back.
// - Soft reset clears registers, sleeps briefly.
// - Reset register write-only, low bits ignored.
// - Power register low bits encode state.
// - Timing bit 3 inverts output clock.
// - Timing bits 2-1 delay output clock.
// - Timing bit 0 enables duty stabilizer.
// - Output mode bit 2 disables outputs.
`timescale 1ns/1ps
`default_nettype none
module adcm_mode_config_port #(
  parameter int SLEEP_CYCLES = adcm_pkg::SRST_SLEEP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_in,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic interface_select_pin,
  input wire logic overflow_in,
  output logic overflow_flag_out,
  output logic overflow_oe_n,
  output logic output_clock_pin,
  output logic output_clock_oe_n,
  output logic data_out_oe_n,
  output logic duty_stabilizer_en,
  output logic [1:0] output_mode_sel,
  output logic [2:0] lvds_current_sel,
  output logic lvds_term_en,
  output logic output_hiz_en,
  output logic [1:0] power_state_sel,
  output logic ch1_nap,
  output logic ch2_nap,
  output logic device_sleep,
  output logic outclk_invert,
  output logic [1:0] outclk_phase_sel
);

  // ==========================================================================
  // Serial port, link clock domain
  // The frame counter is held in reset while chip select is high or while
  // the pins serve as straps, so stray edges outside a frame do nothing.
  wire logic frame_rst_n;
  logic [adcm_pkg::CNT_BITS-1:0] bit_cnt;
  logic [adcm_pkg::SERIAL_WORD_BITS-1:0] shift;
  wire logic [adcm_pkg::SERIAL_WORD_BITS-1:0] next_shift;
  wire logic word_done;
  wire logic header_edge;
  wire logic last_edge;
  wire logic in_data_phase;
  wire logic wr_req;
  wire logic [6:0] wr_addr;
  wire logic [7:0] wr_data;
  logic rd_flag;
  logic [7:0] rd_shift;
  logic sdo_drive;
  logic sdo_bit;
  adcm_pkg::adcm_cfg_type cfg_sck;
  logic upd_tgl;
  logic srst_tgl;

  assign frame_rst_n = rst_n & ~cs_n & ~interface_select_pin;
  assign next_shift = {shift[adcm_pkg::SERIAL_WORD_BITS-2:0], sdi};
  assign word_done =
    (bit_cnt == adcm_pkg::CNT_BITS'(adcm_pkg::SERIAL_WORD_BITS));
  assign header_edge =
    (bit_cnt == adcm_pkg::CNT_BITS'(adcm_pkg::HEADER_BITS - 1));
  assign last_edge =
    (bit_cnt == adcm_pkg::CNT_BITS'(adcm_pkg::SERIAL_WORD_BITS - 1));
  assign in_data_phase =
    (bit_cnt >= adcm_pkg::CNT_BITS'(adcm_pkg::HEADER_BITS)) && !word_done;
  // Only the sixteenth edge commits, so a short frame changes nothing.
  assign wr_req = last_edge && !next_shift[adcm_pkg::RW_POS];
  assign wr_addr = next_shift[adcm_pkg::ADDR_MSB:adcm_pkg::ADDR_LSB];
  assign wr_data = next_shift[adcm_pkg::DATA_BITS-1:0];

  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt <= '0;
      shift <= '0;
    end
    else if (!word_done)
    begin
      bit_cnt <= bit_cnt + adcm_pkg::CNT_BITS'(1);
      shift <= next_shift;
    end
  end

  // Read data is fetched once the header is in and shifted MSB first.
  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      rd_flag <= 1'b0;
      rd_shift <= '0;
    end
    else if (header_edge)
    begin
      rd_flag <= next_shift[adcm_pkg::HDR_RW_POS];
      rd_shift <= adcm_pkg::reg_read(next_shift[adcm_pkg::ADDR_BITS-1:0],
                                     cfg_sck);
    end
    else if (rd_flag && in_data_phase)
    begin
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  // Serial-out changes on falling edges so it is settled at the next rise.
  always_ff @(negedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      sdo_drive <= 1'b0;
      sdo_bit <= 1'b1;
    end
    else
    begin
      sdo_drive <= rd_flag && in_data_phase;
      sdo_bit <= rd_shift[7];
    end
  end

  // Open drain: only a zero is driven; a one relies on the pull-up.
  assign sdo_out = 1'b0;
  assign sdo_oe_n = ~(sdo_drive & ~sdo_bit);

  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_sck <= adcm_pkg::CFG_RESET;
      upd_tgl <= 1'b0;
      srst_tgl <= 1'b0;
    end
    else if (wr_req)
    begin
      upd_tgl <= ~upd_tgl;
      if (wr_addr == adcm_pkg::ADDR_SOFT_RESET)
      begin
        if (wr_data[adcm_pkg::SRST_BIT])
        begin
          cfg_sck <= adcm_pkg::CFG_RESET;
          srst_tgl <= ~srst_tgl;
        end
      end
      else if (wr_addr == adcm_pkg::ADDR_POWER_DOWN)
        cfg_sck.power <= wr_data[adcm_pkg::PWR_MSB:0];
      else if (wr_addr == adcm_pkg::ADDR_OUTCLK_TIMING)
        cfg_sck.timing <= wr_data[adcm_pkg::TIM_MSB:0];
      else if (wr_addr == adcm_pkg::ADDR_OUTPUT_MODE)
        cfg_sck.out_mode <= wr_data;
    end
  end

  // ==========================================================================
  // Crossing into mclk
  // The configuration word stays still for a whole frame after each write,
  // so it is captured only after its toggle has passed the synchroniser.
  logic [4:0] pins_s;
  logic [1:0] tgl_s;
  logic [1:0] tgl_prev;
  wire logic par_mode;
  wire logic cs_s;
  wire logic sck_s;
  wire logic sdi_s;
  wire logic sdo_s;
  wire logic upd_seen;
  wire logic srst_seen;
  adcm_pkg::adcm_cfg_type cfg;

  adcm_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .async_in({interface_select_pin, cs_n, sck, sdi, sdo_in}),
    .sync_out(pins_s)
  );

  adcm_sync #(
    .WIDTH(2)
  ) u_tgl_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .async_in({srst_tgl, upd_tgl}),
    .sync_out(tgl_s)
  );

  assign par_mode = pins_s[4];
  assign cs_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign sdo_s = pins_s[0];
  assign upd_seen = tgl_s[0] ^ tgl_prev[0];
  assign srst_seen = tgl_s[1] ^ tgl_prev[1];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_prev <= '0;
      cfg <= adcm_pkg::CFG_RESET;
    end
    else
    begin
      tgl_prev <= tgl_s;
      if (upd_seen)
        cfg <= cfg_sck;
    end
  end

  // ==========================================================================
  // Soft-reset sleep pulse
  logic [adcm_pkg::SLEEP_CNT_BITS-1:0] sleep_cnt;
  wire logic srst_sleep;

  assign srst_sleep = (sleep_cnt != '0);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_cnt <= '0;
    else if (srst_seen)
      sleep_cnt <= adcm_pkg::SLEEP_CNT_BITS'(SLEEP_CYCLES);
    else if (srst_sleep)
      sleep_cnt <= sleep_cnt - adcm_pkg::SLEEP_CNT_BITS'(1);
  end

  // ==========================================================================
  // Effective settings
  wire logic [1:0] next_power;
  wire logic [1:0] next_mode;
  wire logic [2:0] next_current;
  wire logic next_term;
  wire logic next_hiz;
  wire logic next_dcs;
  wire logic next_invert;
  wire logic [1:0] next_phase;
  wire adcm_pkg::adcm_pwr_ctl_type next_pwr_ctl;

  assign next_power = srst_sleep ? adcm_pkg::ADCM_PWR_SLEEP :
                      par_mode ? {sdi_s, sdo_s} :
                      cfg.power;
  assign next_mode = par_mode ?
    (sck_s ? adcm_pkg::ADCM_OUT_DDR_LVDS : adcm_pkg::ADCM_OUT_FULL_CMOS) :
    cfg.out_mode[adcm_pkg::OM_MODE_MSB:0];
  assign next_current = par_mode ? adcm_pkg::LVDS_CURRENT_DEFAULT :
    cfg.out_mode[adcm_pkg::OM_CURRENT_MSB:adcm_pkg::OM_CURRENT_LSB];
  assign next_term = par_mode ? 1'b0 :
    cfg.out_mode[adcm_pkg::OM_TERM_BIT];
  assign next_hiz = !par_mode && cfg.out_mode[adcm_pkg::OM_HIZ_BIT];
  assign next_dcs = par_mode ? cs_s :
    cfg.timing[adcm_pkg::TIM_DCS_BIT];
  assign next_invert = !par_mode && cfg.timing[adcm_pkg::TIM_INV_BIT];
  assign next_phase = par_mode ? 2'h0 :
    cfg.timing[adcm_pkg::TIM_PHASE_MSB:adcm_pkg::TIM_PHASE_LSB];
  assign next_pwr_ctl = adcm_pkg::decode_power(next_power);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_state_sel <= adcm_pkg::ADCM_PWR_NORMAL;
      ch1_nap <= 1'b0;
      ch2_nap <= 1'b0;
      device_sleep <= 1'b0;
      output_mode_sel <= adcm_pkg::ADCM_OUT_FULL_CMOS;
      lvds_current_sel <= adcm_pkg::LVDS_CURRENT_DEFAULT;
      lvds_term_en <= 1'b0;
      output_hiz_en <= 1'b0;
      duty_stabilizer_en <= 1'b0;
      outclk_invert <= 1'b0;
      outclk_phase_sel <= 2'h0;
    end
    else
    begin
      power_state_sel <= next_power;
      ch1_nap <= next_pwr_ctl.ch1_nap;
      ch2_nap <= next_pwr_ctl.ch2_nap;
      device_sleep <= next_pwr_ctl.sleep;
      output_mode_sel <= next_mode;
      lvds_current_sel <= next_current;
      lvds_term_en <= next_term;
      output_hiz_en <= next_hiz;
      duty_stabilizer_en <= next_dcs;
      outclk_invert <= next_invert;
      outclk_phase_sel <= next_phase;
    end
  end

  // ==========================================================================
  // Output clock and output enables
  // The output clock runs at mclk over eight, so one mclk step is an eighth
  // of its period; a delay beyond three eighths comes from the invert bit.
  logic [adcm_pkg::OUTCLK_STEP_BITS-1:0] phase_cnt;
  wire logic [adcm_pkg::OUTCLK_STEP_BITS-1:0] delayed_cnt;

  assign delayed_cnt = phase_cnt -
    adcm_pkg::OUTCLK_STEP_BITS'(outclk_phase_sel);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_cnt <= '0;
      output_clock_pin <= 1'b0;
      overflow_flag_out <= 1'b0;
    end
    else
    begin
      phase_cnt <= phase_cnt + adcm_pkg::OUTCLK_STEP_BITS'(1);
      output_clock_pin <= delayed_cnt[adcm_pkg::OUTCLK_STEP_BITS-1] ^
                          outclk_invert;
      overflow_flag_out <= overflow_in;
    end
  end

  // The disabled state is slow to enter and leave; it is not a bus mux.
  assign output_clock_oe_n = output_hiz_en;
  assign overflow_oe_n = output_hiz_en;
  assign data_out_oe_n = output_hiz_en;

endmodule
`default_nettype wire

// ==== adcm_assertions.sv ====
// Port-level concurrent checks of the mode-configuration port.
`timescale 1ns/1ps
`default_nettype none
module adcm_assertions #(
  parameter int SLEEP_CYCLES = 25
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_in,
  input wire logic sdo_oe_n,
  input wire logic interface_select_pin,
  input wire logic overflow_oe_n,
  input wire logic output_clock_oe_n,
  input wire logic data_out_oe_n,
  input wire logic duty_stabilizer_en,
  input wire logic [1:0] output_mode_sel,
  input wire logic [2:0] lvds_current_sel,
  input wire logic lvds_term_en,
  input wire logic output_hiz_en,
  input wire logic [1:0] power_state_sel,
  input wire logic ch1_nap,
  input wire logic ch2_nap,
  input wire logic device_sleep,
  input wire logic outclk_invert,
  input wire logic [1:0] outclk_phase_sel
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Sequences
  // Straps need three edges to land, so five quiet cycles are required.
  sequence par_held;
    (interface_select_pin && $stable({cs_n, sck, sdi, sdo_in})) [*5];
  endsequence
  sequence serial_idle;
    (!interface_select_pin && cs_n) [*8];
  endsequence

  // ==========================================================================
  // Properties
  hiz_tristate_a: assert property (
    {overflow_oe_n, output_clock_oe_n, data_out_oe_n} == {3{output_hiz_en}})
    else $error("output enables disagree with output disable");
  nap_order_a: assert property (ch1_nap |-> ch2_nap)
    else $error("channel one naps alone");
  pwr_decode_a: assert property ($stable(power_state_sel) [*2] |->
    {ch1_nap, ch2_nap, device_sleep} == {power_state_sel == 2'b10,
    power_state_sel inside {2'b01, 2'b10}, power_state_sel == 2'b11})
    else $error("power decode wrong");
  par_dcs_a: assert property (par_held |-> duty_stabilizer_en == cs_n)
    else $error("stabilizer strap not followed");
  par_mode_a: assert property (par_held |->
    output_mode_sel == {1'b0, sck} && lvds_current_sel == 3'h0 &&
    !lvds_term_en && !output_hiz_en)
    else $error("output mode strap not followed");
  par_power_a: assert property (
    par_held |-> power_state_sel == {sdi, sdo_in})
    else $error("power strap not followed");
  sdo_release_a: assert property (
    (cs_n || interface_select_pin) [*3] |-> sdo_oe_n)
    else $error("serial out driven outside a frame");
  cfg_hold_a: assert property (serial_idle |->
    $stable({duty_stabilizer_en, output_mode_sel, lvds_current_sel,
    lvds_term_en, output_hiz_en, outclk_invert, outclk_phase_sel}))
    else $error("configuration changed without a frame");
endmodule

bind adcm_mode_config_port adcm_assertions #(
  .SLEEP_CYCLES(SLEEP_CYCLES)
) adcm_assertions_inst (.*);
`default_nettype wire

// ==== adcm_ctrl_model.sv ====
// Controller model: serial master, parallel straps and the serial-out pull-up.
`timescale 1ns/1ps
`default_nettype none
module adcm_ctrl_model (
  output logic sck,
  output logic cs_n,
  output logic sdi,
  output logic sdo_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic interface_select_pin,
  input wire logic [3:0] strap
);
  logic spi_sck = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sdi = 1'b0;

  // The pull-up makes a released serial-out line read high.
  assign sck = interface_select_pin ? strap[2] : spi_sck;
  assign cs_n = interface_select_pin ? strap[3] : spi_cs_n;
  assign sdi = interface_select_pin ? strap[1] : spi_sdi;
  assign sdo_in = interface_select_pin ? strap[0] :
    (sdo_oe_n ? 1'b1 : sdo_out);

  // Fewer than 16 edges gives a truncated frame; sck idles low between frames.
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      spi_sdi = (i < 16) ? w[15-i] : ~spi_sdi;
      #7.5 spi_sck = 1'b1;
      if (i >= 8 && i < 16)
        rd = {rd[6:0], sdo_in};
      #7.5 spi_sck = 1'b0;
    end
    #7.5 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #60;
  endtask
endmodule
`default_nettype wire

// ==== adcm_mode_config_port_tb.sv ====
// Self-checking bench of the mode-configuration port.
`timescale 1ns/1ps
`default_nettype none
module adcm_mode_config_port_tb;
  localparam int SLEEP = 4;
  logic mclk;
  logic rst_n = 1'b0;
  logic interface_select_pin = 1'b0;
  logic overflow_in = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [7:0] rg [0:3];
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int slept = 0;
  int base;
  int p;
  logic [6:0] a;
  logic [7:0] d;
  wire sck, cs_n, sdi, sdo_in, sdo_out, sdo_oe_n, overflow_flag_out;
  wire overflow_oe_n, output_clock_pin, output_clock_oe_n, data_out_oe_n;
  wire duty_stabilizer_en, lvds_term_en, output_hiz_en, ch1_nap, ch2_nap;
  wire device_sleep, outclk_invert;
  wire [1:0] output_mode_sel, power_state_sel, outclk_phase_sel;
  wire [2:0] lvds_current_sel;
  wire [7:0] obs_a = {duty_stabilizer_en, outclk_invert, outclk_phase_sel,
    output_hiz_en, lvds_term_en, output_mode_sel};
  wire [7:0] obs_b = {lvds_current_sel, power_state_sel, ch1_nap, ch2_nap,
    device_sleep};
  wire [7:0] obs_p = {duty_stabilizer_en, output_mode_sel, power_state_sel,
    output_hiz_en, outclk_invert, |outclk_phase_sel};
  wire [7:0] obs_o = {3'h0, sdo_out, overflow_oe_n, output_clock_oe_n,
    data_out_oe_n, overflow_flag_out};

  adcm_mode_config_port #(.SLEEP_CYCLES(SLEEP)) adcm_mode_config_port_inst (.*);
  adcm_ctrl_model adcm_ctrl_model_inst (.*);

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (device_sleep === 1'b1)
      slept <= slept + 1;
  end
  always @(negedge mclk)
    overflow_in <= 1'($urandom);

  // ==========================================================================
  // Helpers
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask
  function automatic logic [7:0] exp_a();
    return {rg[2][0], rg[2][3], rg[2][2:1], rg[3][2], rg[3][3], rg[3][1:0]};
  endfunction
  function automatic logic [7:0] exp_b();
    logic [1:0] s;
    s = rg[1][1:0];
    return {rg[3][6:4], s, s == 2'b10, s inside {2'b01, 2'b10}, s == 2'b11};
  endfunction
  function automatic logic [7:0] rbk(input logic [6:0] ad);
    if (ad == 7'h01)
      return {6'h00, rg[1][1:0]};
    if (ad == 7'h02)
      return {4'h0, rg[2][3:0]};
    return (ad == 7'h03) ? rg[3] : 8'h00;
  endfunction
  task automatic wr(input logic [6:0] ad, input logic [7:0] dt, input int n);
    logic [7:0] r;
    adcm_ctrl_model_inst.xfer({1'b0, ad, dt}, n, r);
    if (n >= 16 && ad inside {7'h01, 7'h02, 7'h03})
      rg[ad[1:0]] = dt;
    if (n >= 16 && ad == 7'h00 && dt[7])
      rg = '{default: 8'h00};
    repeat (8) @(negedge mclk);
    chk(obs_a, exp_a());
    chk(obs_b, exp_b());
  endtask
  task automatic rdc(input logic [6:0] ad);
    logic [7:0] r;
    adcm_ctrl_model_inst.xfer({1'b1, ad, 8'($urandom)}, 16, r);
    chk(r, rbk(ad));
    chk(obs_a, exp_a());
  endtask
  // Rising edges of the output clock are located on the mclk grid.
  task automatic clk_pos(output int q);
    int k;
    k = 0;
    while (output_clock_pin !== 1'b0 && k < 20)
    begin
      @(negedge mclk);
      k++;
    end
    while (output_clock_pin !== 1'b1 && k < 40)
    begin
      @(negedge mclk);
      k++;
    end
    if (k >= 40)
    begin
      fails++;
      end_sim();
    end
    else
      q = cyc % 8;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h70e7_82fd));
    rg = '{default: 8'h00};
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    clk_pos(base);
    // The first serial command is always a soft reset.
    for (int i = 0; i < 2; i++)
    begin
      slept = 0;
      wr(7'h00, 8'hA5, 16);
      chk(8'(slept), 8'(SLEEP));
      wr(7'h01, 8'h02, 16);
    end
    // No conversion data is ever consumed, so the settle waits hold.
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h01, {6'($urandom), 2'(i)}, 16);
      rdc(7'h01);
      repeat (100) @(negedge mclk);
    end
    wr(7'h00, 8'h7F, 16);
    rdc(7'h00);
    wr(7'h55, 8'hFF, 16);
    rdc(7'h55);
    wr(7'h02, 8'h0E, 10);
    wr(7'h02, 8'h09, 20);
    for (int i = 0; i < 14; i++)
    begin
      a = 7'(1 + $urandom % 3);
      d = 8'($urandom);
      if (a == 7'h02 && d[2:1] != 2'b00)
        d[0] = 1'b1;
      if (a == 7'h01 && rg[3][2])
        d[1] = 1'b1;
      wr(a, d, 16);
      if (a == 7'h03 && d[2])
        wr(7'h01, 8'h02, 16);
      rdc(a);
      clk_pos(p);
      chk(8'(p), 8'((base + rg[2][2:1] + 4 * rg[2][3]) % 8));
      chk(obs_o, {4'h0, {3{rg[3][2]}}, overflow_in});
    end
    interface_select_pin = 1'b1;
    for (int s = 0; s < 16; s++)
    begin
      strap = 4'(s);
      repeat (6) @(negedge mclk);
      chk(obs_p, {strap[3], 1'b0, strap[2], strap[1:0], 3'h0});
    end
    interface_select_pin = 1'b0;
    rdc(7'h03);
    end_sim();
  end
  initial
  begin
    #400_000;
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
